// ===== design/prs_pkg.sv
package prs_pkg;
   // array dimensions
   localparam int NCELL = 10;                    // macrocell registers
   localparam int NIN   = 11;                    // dedicated logic inputs
   localparam int NPIN  = NIN + NCELL;           // pins with keepers
   localparam int NVEC  = NCELL + NPIN;          // array inputs: feedback, i/o, inputs
   localparam int NTERM = NCELL + 2;             // cell terms, async and sync reset
   localparam int T_AR  = NCELL;                 // shared asynchronous reset term
   localparam int T_SR  = NCELL + 1;             // shared synchronous reset term
   localparam int IDX_W = 4;
   localparam int AW    = 8;
   localparam int DW    = 32;
   localparam int SIG_W = 64;

   // register offsets
   localparam logic [AW-1:0] A_CFG  = 8'h00;     // polarity, registered, enable
   localparam logic [AW-1:0] A_PRE  = 8'h04;     // preload write, register state read
   localparam logic [AW-1:0] A_SIGL = 8'h08;     // signature low word
   localparam logic [AW-1:0] A_SIGH = 8'h0c;     // signature high word
   localparam logic [AW-1:0] A_SEC  = 8'h10;     // protection fuse and erase
   localparam logic [AW-1:0] A_PIDX = 8'h14;     // pattern term index
   localparam logic [AW-1:0] A_PDAT = 8'h18;     // pattern term mask
   localparam logic [AW-1:0] A_STAT = 8'h1c;     // status

   // field positions
   localparam int CFG_INV = 0;                   // output inversion bits
   localparam int CFG_REG = 10;                  // registered (1) or combinational
   localparam int CFG_OE  = 20;                  // output enable bits
   localparam int CFG_W   = 30;
   localparam int SEC_SET = 0;                   // write 1 programs the fuse
   localparam int SEC_ERA = 1;                   // write 1 erases pattern terms, signature, configuration and fuse
   localparam int ST_BUSY = 0;
   localparam int ST_SEC  = 1;
   localparam int ST_REF  = 2;
   localparam int ST_SUP  = 3;

   // reset values
   localparam logic [CFG_W-1:0] CFG_RST = 30'h0;
   localparam logic [SIG_W-1:0] SIG_RST = 64'h0;

   // power-up clearing interval
   localparam int CLK_MHZ       = 125;
   localparam int CLR_INTERVAL_NS = 1000;
   localparam int CLR_CYC       = CLR_INTERVAL_NS * CLK_MHZ / 1000;
   localparam int CNT_W         = 8;
   localparam logic [CNT_W-1:0] CLR_LAST = 8'(CLR_CYC - 1);

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } prs_bus_s;
endpackage : prs_pkg

// ===== design/prs_keeper.sv
`timescale 1ns/1ns
`default_nettype none
module prs_keeper #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i,   // system clock
   input  wire logic         rst_n_i,     // synchronised reset
   input  wire logic [W-1:0] lvl_i,       // synchronised pin level
   input  wire logic [W-1:0] drv_i,       // pin actively driven
   output logic      [W-1:0] res_o,       // level seen by the array
   output logic      [W-1:0] hold_o,      // weak keeper level
   output logic      [W-1:0] hold_oe_o    // keeper drives the pin
);
   typedef struct packed {
      logic [W-1:0] last;
   } prs_kp_s;

   prs_kp_s s_r, s_nxt;

   // remember the last driven level per pin
   always_comb begin
      s_nxt = s_r;
      for (int i = 0; i < W; i++) begin
         if (drv_i[i]) begin
            s_nxt.last[i] = lvl_i[i];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // a real driver wins at once, the keeper only fills in
   generate
      for (genvar g = 0; g < W; g++) begin : g_pin
         assign res_o[g]     = drv_i[g] ? lvl_i[g] : s_r.last[g];
         assign hold_o[g]    = s_r.last[g];
         assign hold_oe_o[g] = ~drv_i[g];
      end
   endgenerate
endmodule : prs_keeper
`default_nettype wire

// ===== design/prs_top.sv
// How it works
// - supply below threshold or clearing interval forces all registers low, no clock
// - each output pin shows its register value, or its term when combinational, through its configured polarity
// - preload write forces each register high or low individually
// - sixty-four bit signature store, readable at all times
// - fuse set blocks pattern readback and preload at once, signature stays
// - undriven pins keep their last driven level
// - any real driver overrides the held level immediately
// - shared async and sync reset terms act on all cells, cleared at power-up
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module prs_top
   import prs_pkg::*;
(
   input  wire logic                      clk_sys_i,  // system clock
   input  wire logic                      arst_n_i,   // async reset
   input  wire prs_pkg::prs_bus_s         bus_i,      // register request
   output logic      [prs_pkg::DW-1:0]    rdata_o,    // read data
   input  wire logic                      supply_ok_i,// supply above threshold
   input  wire logic                      dev_clk_i,  // device clock pin
   input  wire logic [prs_pkg::NIN-1:0]   in_i,       // input pin levels
   input  wire logic [prs_pkg::NIN-1:0]   in_drv_i,   // inputs driven by board
   input  wire logic [prs_pkg::NCELL-1:0] io_i,       // i/o pin levels
   input  wire logic [prs_pkg::NCELL-1:0] io_drv_i,   // i/o driven by board
   output logic      [prs_pkg::NCELL-1:0] io_o,       // i/o drive level
   output logic      [prs_pkg::NCELL-1:0] io_oe_o,    // i/o drive enable
   output logic      [prs_pkg::NPIN-1:0]  keep_o,     // keeper level
   output logic      [prs_pkg::NPIN-1:0]  keep_oe_o   // keeper weak enable
);
   import prs_pkg::*;

   typedef struct packed {
      logic                          sup1;
      logic                          sup2;
      logic                          ck1;
      logic                          ck2;
      logic                          ck3;
      logic [NPIN-1:0]               pin1;
      logic [NPIN-1:0]               pin2;
      logic [NPIN-1:0]               drv1;
      logic [NPIN-1:0]               drv2;
      logic                          busy;
      logic [CNT_W-1:0]              cnt;
      logic [NCELL-1:0]              q;
      logic [CFG_W-1:0]              cfg;
      logic [SIG_W-1:0]              sig;
      logic                          fuse;
      logic [IDX_W-1:0]              idx;
      logic [NTERM-1:0][NVEC-1:0]    pat;
      logic                          refused;
      logic [DW-1:0]                 rdata;
      logic [NCELL-1:0]              olvl;
      logic [NCELL-1:0]              ooe;
   } prs_state_s;

   prs_state_s       s_r, s_nxt;
   logic [1:0]       rst_sync_r;
   logic             rst_n;
   logic [NPIN-1:0]  res;
   logic [NPIN-1:0]  pin_drv;
   logic [NVEC-1:0]  vec;
   logic [NTERM-1:0] term;
   logic [NCELL-1:0] cell_val;
   logic             ck_rise;
   logic             wr_ok;

   // product term: empty mask is inactive
   function automatic logic term_f(input logic [NVEC-1:0] m,
                                   input logic [NVEC-1:0] v);
      return (|m) & (&(v | ~m));
   endfunction : term_f

   // reset release through two flops
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // own drive counts as a driver on i/o pins
   assign pin_drv = {s_r.drv2[NPIN-1:NIN] | s_r.ooe, s_r.drv2[NIN-1:0]};

   prs_keeper #(
      .W (NPIN)
   ) u_keeper (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .lvl_i     (s_r.pin2),
      .drv_i     (pin_drv),
      .res_o     (res),
      .hold_o    (keep_o),
      .hold_oe_o (keep_oe_o)
   );

   // array inputs and terms
   assign vec     = {s_r.q, res};
   assign ck_rise = s_r.ck2 & ~s_r.ck3;
   generate
      for (genvar g = 0; g < NTERM; g++) begin : g_term
         assign term[g] = term_f(s_r.pat[g], vec);
      end
      for (genvar g = 0; g < NCELL; g++) begin : g_cell
         assign cell_val[g] = s_r.cfg[CFG_REG + g] ? s_r.q[g] : term[g];
      end
   endgenerate

   // next state
   always_comb begin
      s_nxt = s_r;
      wr_ok = bus_i.wr & ~s_r.fuse;

      // synchronisers
      s_nxt.sup1 = supply_ok_i;
      s_nxt.sup2 = s_r.sup1;
      s_nxt.ck1  = dev_clk_i;
      s_nxt.ck2  = s_r.ck1;
      s_nxt.ck3  = s_r.ck2;
      s_nxt.pin1 = {io_i, in_i};
      s_nxt.pin2 = s_r.pin1;
      s_nxt.drv1 = {io_drv_i, in_drv_i};
      s_nxt.drv2 = s_r.drv1;

      // clearing interval after the supply comes up
      if (!s_r.sup2) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt  = '0;
      end else if (s_r.busy) begin
         if (s_r.cnt == CLR_LAST) begin
            s_nxt.busy = 1'b0;
         end else begin
            s_nxt.cnt = s_r.cnt + 8'h1;
         end
      end

      // macrocell registers
      if (!s_r.sup2 || s_r.busy) begin
         s_nxt.q = '0;
      end else if (term[T_AR]) begin
         s_nxt.q = '0;
      end else if (bus_i.wr && bus_i.addr == A_PRE && !s_r.fuse) begin
         s_nxt.q = bus_i.wdata[NCELL-1:0];
      end else if (ck_rise) begin
         s_nxt.q = term[T_SR] ? '0 : term[NCELL-1:0];
      end

      // register writes
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            A_CFG:  s_nxt.cfg = bus_i.wdata[CFG_W-1:0];
            A_SIGL: if (wr_ok) s_nxt.sig[31:0] = bus_i.wdata;
            A_SIGH: if (wr_ok) s_nxt.sig[63:32] = bus_i.wdata;
            A_PIDX: s_nxt.idx = bus_i.wdata[IDX_W-1:0];
            A_PDAT: begin
               if (wr_ok && int'(s_r.idx) < NTERM) begin
                  s_nxt.pat[s_r.idx] = bus_i.wdata[NVEC-1:0];
               end
            end
            A_SEC: begin
               if (bus_i.wdata[SEC_ERA]) begin
                  s_nxt.pat  = '0;
                  s_nxt.sig  = SIG_RST;
                  s_nxt.cfg  = CFG_RST;
                  s_nxt.fuse = 1'b0;
               end else if (bus_i.wdata[SEC_SET]) begin
                  s_nxt.fuse = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // read data, one cycle later
      s_nxt.rdata = '0;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            A_CFG:  s_nxt.rdata = {2'h0, s_r.cfg};
            A_PRE:  s_nxt.rdata = {22'h0, s_r.q};
            A_SIGL: s_nxt.rdata = s_r.sig[31:0];
            A_SIGH: s_nxt.rdata = s_r.sig[63:32];
            A_SEC:  s_nxt.rdata = {31'h0, s_r.fuse};
            A_PIDX: s_nxt.rdata = {28'h0, s_r.idx};
            A_PDAT: begin
               if (!s_r.fuse && int'(s_r.idx) < NTERM) begin
                  s_nxt.rdata = {1'h0, s_r.pat[s_r.idx]};
               end
            end
            A_STAT: begin
               s_nxt.rdata[ST_BUSY] = s_r.busy;
               s_nxt.rdata[ST_SEC]  = s_r.fuse;
               s_nxt.rdata[ST_REF]  = s_r.refused;
               s_nxt.rdata[ST_SUP]  = s_r.sup2;
               s_nxt.refused        = 1'b0;
            end
            default: ;
         endcase
      end

      // refused access flag, set wins over clear
      if (s_r.fuse && ((bus_i.rd && bus_i.addr == A_PDAT) ||
                       (bus_i.wr && (bus_i.addr == A_PRE || bus_i.addr == A_PDAT ||
                                     bus_i.addr == A_SIGL || bus_i.addr == A_SIGH)))) begin
         s_nxt.refused = 1'b1;
      end

      // output pins through their polarity
      s_nxt.olvl = cell_val ^ s_r.cfg[CFG_INV +: NCELL];
      s_nxt.ooe  = s_r.cfg[CFG_OE +: NCELL];
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         s_r      <= '0;
         s_r.busy <= 1'b1;
         s_r.cfg  <= CFG_RST;
         s_r.sig  <= SIG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rdata;
   assign io_o    = s_r.olvl;
   assign io_oe_o = s_r.ooe;
endmodule : prs_top
`default_nettype wire

// ===== dv/prs_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module prs_top_props
   import prs_pkg::*;
(
   input wire logic                     clk_sys_i,   // system clock
   input wire logic                     arst_n_i,    // async reset
   input wire prs_pkg::prs_bus_s        bus_i,       // register request
   input wire logic [prs_pkg::DW-1:0]   rdata_o,     // read data
   input wire logic                     supply_ok_i, // supply good
   input wire logic [prs_pkg::NIN-1:0]  in_i,        // input levels
   input wire logic [prs_pkg::NIN-1:0]  in_drv_i,    // inputs driven
   input wire logic [prs_pkg::NPIN-1:0] keep_o,      // keeper level
   input wire logic [prs_pkg::NPIN-1:0] keep_oe_o    // keeper enable
);
   logic       sec_r;
   logic [7:0] up_r;
   logic       ready;
   // fuse state and time since the supply came good
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sec_r <= 1'b0;
         up_r  <= 8'h0;
      end else begin
         if (bus_i.wr && bus_i.addr == A_SEC) sec_r <= !bus_i.wdata[SEC_ERA] && (sec_r || bus_i.wdata[SEC_SET]);
         up_r <= !supply_ok_i ? 8'h0 : up_r + 8'(up_r < 8'ha0);
      end
   end
   assign ready = up_r == 8'ha0 && !sec_r;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   sequence pre_wr; bus_i.wr && bus_i.addr == A_PRE; endsequence
   sequence pre_rd; bus_i.rd && bus_i.addr == A_PRE; endsequence
   rd_idle_a: assert property (!bus_i.rd |=> rdata_o == '0) else $error("read data outside slot");
   clear_low_a: assert property ((!supply_ok_i) [*4] ##0 pre_rd |=> rdata_o == '0)
      else $error("register not cleared");
   clear_wait_a: assert property ($rose(supply_ok_i) ##[4:120] pre_rd |=> rdata_o == '0)
      else $error("register left clearing early");
   preload_set_a: assert property (ready ##0 pre_wr ##2 pre_rd
      |=> rdata_o[NCELL-1:0] == $past(bus_i.wdata[NCELL-1:0], 3)) else $error("preload lost");
   fuse_block_a: assert property (sec_r && bus_i.rd && bus_i.addr == A_PDAT |=> rdata_o == '0)
      else $error("pattern readable when secured");
   fuse_flag_a: assert property (sec_r && bus_i.rd && bus_i.addr == A_STAT |=> rdata_o[ST_SEC])
      else $error("fuse flag missing");
   keep_hold_a: assert property ((!in_drv_i[5]) [*4] |-> keep_oe_o[5])
      else $error("keeper idle on floating pin");
   keep_follow_a: assert property ((in_drv_i[5] && !in_i[5]) [*6] |-> !keep_o[5])
      else $error("keeper not overridden");
endmodule : prs_top_props
bind prs_top prs_top_props props (.clk_sys_i, .arst_n_i, .bus_i, .rdata_o, .supply_ok_i, .in_i,
   .in_drv_i, .keep_o, .keep_oe_o);
`default_nettype wire

// ===== dv/prs_board.sv
`timescale 1ns/1ns
`default_nettype none
module prs_board
   import prs_pkg::*;
(
   input  wire logic clk_sys_i, // system clock
   input  wire logic supply_i,  // supply good
   input  wire logic req_i,     // request a clock pulse
   input  wire logic early_i,   // pulse even inside clearing
   output logic      dev_clk_o, // device clock pin
   output logic      busy_o     // pulse under way
);
   logic [7:0] up_r = 8'h0;
   logic [3:0] ph_r = 4'h0;
   // wait out the clearing interval, then shape a pulse
   always_ff @(posedge clk_sys_i) begin
      up_r <= !supply_i ? 8'h0 : up_r + 8'(up_r != 8'hff);
      if (ph_r != 4'h0) ph_r <= ph_r - 4'h1;
      else if (req_i && (early_i || up_r > 8'(CLR_CYC + 4))) ph_r <= 4'ha;
   end
   // two quiet cycles of input setup before the rise
   assign dev_clk_o = ph_r >= 4'h5 && ph_r <= 4'h8;
   assign busy_o    = ph_r != 4'h0;
endmodule : prs_board
`default_nettype wire

// ===== dv/prs_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module prs_top_tb;
   import prs_pkg::*;
   logic             clk_sys_i = 1'b0;
   logic             arst_n_i  = 1'b0;
   prs_bus_s         bus       = '0;
   logic             supply    = 1'b0;
   logic             req       = 1'b0;
   logic             early     = 1'b0;
   logic [NIN-1:0]   in_lvl    = '0;
   logic [NIN-1:0]   in_drv    = '1;
   logic [NCELL-1:0] io_lvl    = '0;
   logic [NCELL-1:0] io_drv    = '0;
   logic [NCELL-1:0] pats [2]  = '{10'h2aa, 10'h155};
   logic [DW-1:0]    rdata;
   logic [NCELL-1:0] io_o;
   logic [NCELL-1:0] io_oe;
   logic [NCELL-1:0] io_w;
   logic [NIN-1:0]   in_w;
   logic [NPIN-1:0]  keep;
   logic [NPIN-1:0]  keep_oe;
   logic             dev_clk;
   logic             bsy;
   int               fail_count  = 0;
   int               comparisons = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   // floating pins settle to the keeper level
   assign in_w = (in_drv & in_lvl) | (~in_drv & keep[NIN-1:0]);
   assign io_w = (io_oe & io_o) | (~io_oe & io_drv & io_lvl) | (~io_oe & ~io_drv & keep[NPIN-1:NIN]);
   prs_top dut (.clk_sys_i, .arst_n_i, .bus_i(bus), .rdata_o(rdata), .supply_ok_i(supply),
      .dev_clk_i(dev_clk), .in_i(in_w), .in_drv_i(in_drv), .io_i(io_w), .io_drv_i(io_drv), .io_o,
      .io_oe_o(io_oe), .keep_o(keep), .keep_oe_o(keep_oe));
   prs_board board (.clk_sys_i, .supply_i(supply), .req_i(req), .early_i(early),
      .dev_clk_o(dev_clk), .busy_o(bsy));
   task automatic give_verdict();
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : idle
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus <= '0;
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus <= '0;
      #1 chk(rdata, exp);
   endtask : rd
   task automatic pulse(input logic e);
      @(posedge clk_sys_i);
      early <= e;
      req   <= 1'b1;
      @(posedge clk_sys_i);
      req   <= 1'b0;
      // the board took the request at the last edge, busy shows from this one
      @(posedge clk_sys_i);
      while (bsy) @(posedge clk_sys_i);
      idle(6);
   endtask : pulse
   // watchdog
   initial begin
      idle(4000);
      fail_count++;
      give_verdict();
   end
   initial begin
      idle(12);
      arst_n_i <= 1'b1;
      idle(3);
      wr(A_PIDX, 32'h0);
      wr(A_PDAT, 32'h4);
      in_lvl[2] <= 1'b1;
      idle(4);
      rd(A_PRE, 32'h0);
      supply <= 1'b1;
      idle(10);
      pulse(1'b1);
      rd(A_PRE, 32'h0);
      idle(130);
      rd(A_STAT, 32'h8);
      chk(32'(io_o), 32'h1);
      wr(A_CFG, 32'h3fff_fd55);
      idle(3);
      chk(32'({io_oe, io_o}), 32'hf_fd55);
      foreach (pats[k]) begin
         wr(A_PRE, 32'(pats[k]));
         rd(A_PRE, 32'(pats[k]));
         chk(32'(io_o), 32'(pats[k] ^ 10'h155));
      end
      pulse(1'b0);
      rd(A_PRE, 32'h1);
      wr(A_PIDX, 32'hb);
      wr(A_PDAT, 32'h2);
      in_lvl[1] <= 1'b1;
      idle(5);
      rd(A_PRE, 32'h1);
      pulse(1'b0);
      rd(A_PRE, 32'h0);
      in_lvl[1] <= 1'b0;
      wr(A_PIDX, 32'ha);
      wr(A_PDAT, 32'h1);
      wr(A_PRE, 32'h3ff);
      rd(A_PDAT, 32'h1);
      rd(A_PRE, 32'h3ff);
      in_lvl[0] <= 1'b1;
      idle(5);
      rd(A_PRE, 32'h0);
      in_lvl[0] <= 1'b0;
      in_lvl[5] <= 1'b1;
      idle(8);
      in_drv[5] <= 1'b0;
      in_lvl[5] <= 1'b0;
      idle(8);
      chk(32'({keep_oe[5], keep[5], in_w[5]}), 32'h7);
      in_drv[5] <= 1'b1;
      idle(8);
      chk(32'({keep_oe[5], keep[5], in_w[5]}), 32'h0);
      wr(A_SIGL, 32'h89ab_cdef);
      wr(A_SIGH, 32'h0123_4567);
      wr(A_SEC, 32'h1);
      rd(A_PDAT, 32'h0);
      wr(A_PRE, 32'h3ff);
      rd(A_PRE, 32'h0);
      rd(A_STAT, 32'he);
      rd(A_STAT, 32'ha);
      wr(A_SIGL, 32'h0);
      rd(A_SIGL, 32'h89ab_cdef);
      rd(A_SIGH, 32'h0123_4567);
      wr(A_SEC, 32'h2);
      rd(A_SEC, 32'h0);
      rd(A_SIGL, 32'h0);
      // i/o pin released by the device, driven and then left by the board
      io_drv[3] <= 1'b1;
      io_lvl[3] <= 1'b1;
      idle(8);
      chk(32'({keep_oe[NIN+3], keep[NIN+3], io_w[3]}), 32'h3);
      io_drv[3] <= 1'b0;
      io_lvl[3] <= 1'b0;
      idle(8);
      chk(32'({keep_oe[NIN+3], keep[NIN+3], io_w[3]}), 32'h7);
      give_verdict();
   end
endmodule : prs_top_tb
`default_nettype wire
